// *** hdl/acr_pin_sync.sv ***
`timescale 1ns/1ns
module acr_pin_sync
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  acr_sync_if.sync port
);
  typedef struct packed {
    logic [PIN_W-1:0] m1;
    logic [PIN_W-1:0] m2;
    logic [PIN_W-1:0] m3;
  } acr_sync_s;

  acr_sync_s st_r;
  acr_sync_s st_nxt;

  // First stage feeds only the second; edges look at stages two and three
  always_comb begin
    st_nxt = st_r;
    st_nxt.m1 = port.raw;
    st_nxt.m2 = st_r.m1;
    st_nxt.m3 = st_r.m2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port.lvl = st_r.m2;
  assign port.rise = st_r.m2 & ~st_r.m3;
  assign port.fall = ~st_r.m2 & st_r.m3;
endmodule : acr_pin_sync

// *** hdl/acr_pkg.sv ***
package acr_pkg;

  // Pin order inside the synchroniser bundle
  localparam int PIN_W = 3;
  localparam int PIN_CNV = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SCK = 2;

  // Conversion timing: longest conversion time, rounded down to cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 300;
  localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

  // Readout word layout
  localparam int RESULT_BITS = 20;
  localparam int STATUS_BITS = 6;
  localparam int WORD_BITS = 27;
  localparam logic [4:0] LEN_DATA = 5'h14;
  localparam logic [4:0] LEN_STAT = 5'h1a;

  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;

  // Configuration fields
  localparam int CFG_W = 4;
  localparam int CFG_TURBO = 0;
  localparam int CFG_STAT_EN = 1;
  localparam int CFG_SPAN = 2;
  localparam int CFG_HIGHZ = 3;
  localparam logic [3:0] CFG_RST = 4'h0;

  // Status register fields
  localparam int STS_CONV = 0;
  localparam int STS_RD_LO = 1;
  localparam int STS_TURBO_CAP = 3;
  localparam int STS_OE = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_ARMED = 2'b01,
    RD_SHIFT = 2'b10
  } acr_rd_e;

endpackage : acr_pkg

// *** hdl/acr_readout.sv ***
// How it works
// [RULE_01] Host keeps turbo cleared for non-turbo modes; turbo resets to zero.
// [RULE_02] Host holds the serial input high during 3-wire conversions.
// [RULE_03] Conversion-start rising edge begins a conversion and releases the output.
// [RULE_04] A 3-wire non-busy conversion completes whatever conversion-start does later.
// [RULE_05] Host returns conversion-start high in time to avoid busy indication.
// [RULE_06] Host keeps SCK quiet during conversion.
// [RULE_07] Conversion-start fall presents MSB; SCK falling edges shift the rest.
// [RULE_08] Output releases after edge 20, or after edge 26 with status.
// [RULE_09] 3-wire non-busy and turbo release at last edge or conversion-start rise.
// [RULE_10] Busy mode keeps the output released until conversion completes.
// [RULE_11] Host holds conversion-start low through conversion for busy indication.
// [RULE_12] Busy mode drives output low at completion, then shifts MSB first.
// [RULE_13] Result fills the first twenty falling edges, then optional status.
// [RULE_14] Busy mode releases after one extra edge or conversion-start rise.
// [RULE_15] Host keeps shared-output contention short; output survives it.
// [RULE_16] Turbo mode shifts out the previous conversion's result.
// [RULE_17] Host holds conversion-start high in 4-wire modes, serial input high at start.
// [RULE_18] Host waits first quiet interval before selecting in turbo mode.
// [RULE_19] 4-wire serial input fall presents MSB; SCK falling edges shift the rest.
// [RULE_20] Host leaves second quiet interval before next conversion start.
// [RULE_21] Host may borrow serial input early, but raises it in time.
// [RULE_22] 4-wire non-busy releases at last edge or serial input rise.
// [RULE_23] Status order: clamp flag, span, high-impedance, turbo, two reserved zeros.
// [RULE_24] Readout behaviour chosen from turbo setting and pins at conversion start; pins unused then, busy set by conversion-start level at completion.
// [RULE_25] Count falling edges; release once the final bit is passed.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module acr_readout
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic conversion_start,
  input wire logic serial_input_line,
  input wire logic sck,
  output logic serial_output_line_o,
  output logic serial_output_line_oe,
  input wire logic [RESULT_BITS-1:0] sample_in,
  input wire logic overvoltage_clamp_flag,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic conv_busy;
    logic [7:0] conv_cnt;
    logic turbo_cap;
    logic [RESULT_BITS-1:0] result;
    logic [RESULT_BITS-1:0] prev;
    acr_rd_e rd;
    logic rel_sdi;
    logic [WORD_BITS-1:0] shreg;
    logic [4:0] bit_cnt;
    logic [4:0] limit;
    logic oe;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [CFG_W-1:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acr_state_s;

  acr_state_s st_r;
  acr_state_s st_nxt;

  acr_sync_if pins ();

  assign pins.raw[PIN_CNV] = conversion_start;
  assign pins.raw[PIN_SDI] = serial_input_line;
  assign pins.raw[PIN_SCK] = sck;

  acr_pin_sync u_sync (
    .clk(clk),
    .srst(srst),
    .port(pins.sync)
  );

  logic cnv_lvl;
  logic cnv_rise;
  logic cnv_fall;
  logic sdi_rise;
  logic sdi_fall;
  logic sck_fall;
  logic conv_done;
  logic rd_load;
  logic [STATUS_BITS-1:0] stat_bits;

  assign cnv_lvl = pins.lvl[PIN_CNV];
  assign cnv_rise = pins.rise[PIN_CNV];
  assign cnv_fall = pins.fall[PIN_CNV];
  assign sdi_rise = pins.rise[PIN_SDI];
  assign sdi_fall = pins.fall[PIN_SDI];
  assign sck_fall = pins.fall[PIN_SCK];

  // Busy framing puts a leading zero ahead of the MSB and stretches by one edge
  function automatic logic [WORD_BITS-1:0] pack_word(input logic [RESULT_BITS-1:0] d,
                                                     input logic [STATUS_BITS-1:0] s,
                                                     input logic busy);
    return busy ? {1'b0, d, s} : {d, s, 1'b0};
  endfunction : pack_word

  function automatic logic [4:0] word_len(input logic stat_en, input logic busy);
    logic [4:0] len;
    len = stat_en ? LEN_STAT : LEN_DATA;
    return busy ? len + 5'h01 : len;
  endfunction : word_len

  always_comb begin
    st_nxt = st_r;
    rd_load = 1'b0;
    stat_bits = {overvoltage_clamp_flag, st_r.cfg[CFG_SPAN], st_r.cfg[CFG_HIGHZ],
                 st_r.cfg[CFG_TURBO], 2'b00}; // RULE_23
    conv_done = st_r.conv_busy && (st_r.conv_cnt == CONV_LAST);

    // Conversion timer ignores both pins once running
    if (st_r.conv_busy) begin
      st_nxt.conv_cnt = st_r.conv_cnt + 8'h01; // RULE_04
    end
    if (conv_done) begin
      st_nxt.conv_busy = 1'b0;
      st_nxt.result = sample_in;
    end

    unique case (st_r.rd)
      RD_IDLE: begin
        if (conv_done && !st_r.turbo_cap) begin
          if (!cnv_lvl) begin
            // Busy indication: drive low now, MSB after the next falling edge
            st_nxt.shreg = pack_word(sample_in, stat_bits, 1'b1); // RULE_12
            st_nxt.limit = word_len(st_r.cfg[CFG_STAT_EN], 1'b1); // RULE_14
            st_nxt.bit_cnt = 5'h00;
            st_nxt.rel_sdi = 1'b0;
            st_nxt.rd = RD_SHIFT;
            rd_load = 1'b1;
          end else begin
            st_nxt.rd = RD_ARMED; // RULE_24
          end
        end
      end
      RD_ARMED: begin
        if (st_r.turbo_cap) begin
          if (sdi_fall) begin
            st_nxt.shreg = pack_word(st_r.prev, stat_bits, 1'b0); // RULE_16
            st_nxt.rel_sdi = 1'b0;
            st_nxt.rd = RD_SHIFT;
            rd_load = 1'b1;
          end
        end else if (cnv_fall || sdi_fall) begin
          st_nxt.shreg = pack_word(st_r.result, stat_bits, 1'b0); // RULE_07 RULE_19
          st_nxt.rel_sdi = !cnv_fall; // RULE_22
          st_nxt.rd = RD_SHIFT;
          rd_load = 1'b1;
        end
        if (rd_load) begin
          st_nxt.limit = word_len(st_r.cfg[CFG_STAT_EN], 1'b0); // RULE_08 RULE_13
          st_nxt.bit_cnt = 5'h00;
        end
      end
      RD_SHIFT: begin
        if (sck_fall) begin
          st_nxt.shreg = {st_r.shreg[WORD_BITS-2:0], 1'b0};
          st_nxt.bit_cnt = st_r.bit_cnt + 5'h01; // RULE_25
          if (st_r.bit_cnt + 5'h01 == st_r.limit) begin
            st_nxt.rd = RD_IDLE; // RULE_08 RULE_09
          end
        end
        if (sdi_rise && st_r.rel_sdi) begin
          st_nxt.rd = RD_IDLE; // RULE_22
        end
      end
      default: st_nxt.rd = RD_IDLE;
    endcase

    // A new conversion-start edge outranks any readout in progress
    if (cnv_rise) begin
      st_nxt.rd = RD_IDLE; // RULE_03 RULE_09 RULE_14
      if (!st_r.conv_busy) begin
        st_nxt.conv_busy = 1'b1; // RULE_03
        st_nxt.conv_cnt = 8'h00;
        st_nxt.turbo_cap = st_r.cfg[CFG_TURBO]; // RULE_24
        if (st_r.cfg[CFG_TURBO]) begin
          st_nxt.prev = conv_done ? sample_in : st_r.result; // RULE_16
          st_nxt.rd = RD_ARMED;
        end
      end
    end
    st_nxt.oe = (st_nxt.rd == RD_SHIFT); // RULE_10

    // Register bus: address and data taken independently, answered together
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata[CFG_W-1:0];
      st_nxt.w_strb0 = s_axi_wstrb[0];
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (st_r.aw_addr == REG_CFG) begin
        if (st_r.w_strb0) begin
          st_nxt.cfg = st_r.w_data; // RULE_01
        end
      end else if (st_r.aw_addr != REG_STATUS && st_r.aw_addr != REG_RESULT) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end

    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr == REG_CFG) begin
        st_nxt.rdata[CFG_W-1:0] = st_r.cfg;
      end else if (s_axi_araddr == REG_STATUS) begin
        st_nxt.rdata[STS_CONV] = st_r.conv_busy;
        st_nxt.rdata[STS_RD_LO +: 2] = st_r.rd;
        st_nxt.rdata[STS_TURBO_CAP] = st_r.turbo_cap;
        st_nxt.rdata[STS_OE] = st_r.oe;
      end else if (s_axi_araddr == REG_RESULT) begin
        st_nxt.rdata[RESULT_BITS-1:0] = st_r.result;
      end else begin
        st_nxt.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.cfg <= CFG_RST; // RULE_01
    end else begin
      st_r <= st_nxt;
    end
  end

  assign serial_output_line_o = st_r.shreg[WORD_BITS-1];
  assign serial_output_line_oe = st_r.oe;
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_start_release: assert property ( // RULE_03
    cnv_rise && !st_r.conv_busy |=> st_r.conv_busy && !serial_output_line_oe && st_r.conv_cnt == 8'h00)
    else $error("conversion start did not begin conversion with output released");

  a_conv_runs: assert property ( // RULE_04
    st_r.conv_busy && st_r.conv_cnt != CONV_LAST |=> st_r.conv_busy)
    else $error("conversion ended early");

  a_conv_quiet: assert property ( // RULE_10
    st_r.conv_busy && !st_r.turbo_cap |-> !serial_output_line_oe)
    else $error("output driven during non-turbo conversion");

  a_busy_low: assert property ( // RULE_12
    conv_done && !st_r.turbo_cap && !cnv_lvl && !cnv_rise |=>
      serial_output_line_oe && !serial_output_line_o ##0 st_r.bit_cnt == 5'h00)
    else $error("busy indication not driven low at completion");

  a_msb_first: assert property ( // RULE_07
    st_r.rd == RD_ARMED && !st_r.turbo_cap && (cnv_fall || sdi_fall) && !cnv_rise |=>
      serial_output_line_oe && serial_output_line_o == st_r.result[RESULT_BITS-1])
    else $error("MSB not presented at select");

  a_turbo_prev: assert property ( // RULE_16
    st_r.rd == RD_ARMED && st_r.turbo_cap && sdi_fall && !cnv_rise |=>
      serial_output_line_o == $past(st_r.prev[RESULT_BITS-1]))
    else $error("turbo readout not from previous result");

  a_last_release: assert property ( // RULE_25
    st_r.rd == RD_SHIFT && sck_fall && st_r.bit_cnt + 5'h01 == st_r.limit |=> !serial_output_line_oe)
    else $error("output still driven after final bit");

  a_len_plain: assert property ( // RULE_08
    rd_load && !st_r.cfg[CFG_STAT_EN] && st_r.rd == RD_ARMED && !cnv_rise |=> st_r.limit == LEN_DATA)
    else $error("wrong frame length without status");

  a_cnv_release: assert property ( // RULE_09
    cnv_rise |=> !serial_output_line_oe)
    else $error("output not released on conversion start");

  a_sdi_release: assert property ( // RULE_22
    st_r.rd == RD_SHIFT && st_r.rel_sdi && sdi_rise |=> !serial_output_line_oe)
    else $error("output not released on serial input rise");

  // Busy frames carry the status one place lower, behind the leading zero
  a_status_bits: assert property ( // RULE_23
    rd_load && !cnv_rise |=> (($past(st_r.rd) == RD_ARMED) ? st_r.shreg[STATUS_BITS:1] == $past(stat_bits) :
      st_r.shreg[STATUS_BITS-1:0] == $past(stat_bits)))
    else $error("status bits misplaced");

  a_mode_pick: assert property ( // RULE_24
    cnv_rise && !st_r.conv_busy |=> st_r.turbo_cap == $past(st_r.cfg[CFG_TURBO]))
    else $error("readout mode not captured at conversion start");

  a_busy_len: assert property ( // RULE_14
    rd_load && st_r.rd == RD_IDLE && !cnv_rise |=>
      st_r.limit == (($past(st_r.cfg[CFG_STAT_EN]) ? LEN_STAT : LEN_DATA) + 5'h01))
    else $error("busy frame length lacks the extra release edge");

  a_sdi_select: assert property ( // RULE_19
    st_r.rd == RD_ARMED && !st_r.turbo_cap && sdi_fall && !cnv_fall && !cnv_rise |=>
      serial_output_line_oe && st_r.rel_sdi)
    else $error("serial input select did not start a 4-wire readout");

  c_busy_frame: cover property (st_r.rd == RD_SHIFT && st_r.limit == 5'h15 && sck_fall);
  c_turbo_read: cover property (st_r.turbo_cap && st_r.conv_busy && st_r.rd == RD_SHIFT);
  c_sdi_read: cover property (st_r.rel_sdi && st_r.rd == RD_SHIFT && sdi_rise);
endmodule : acr_readout

// *** hdl/acr_sync_if.sv ***
`timescale 1ns/1ns
interface acr_sync_if;
  import acr_pkg::*;
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;
  modport sync (input raw, output lvl, output rise, output fall);
  modport user (output raw, input lvl, input rise, input fall);
endinterface : acr_sync_if

// *** testbench/acr_host.sv ***
`timescale 1ns/1ns
module acr_host (
  input wire logic clk,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  output logic conversion_start,
  output logic serial_input_line,
  output logic sck
);
  logic sdo_wire;
  // Pull-up on the line, so a released output reads high
  assign sdo_wire = sdo_oe ? sdo_o : 1'b1;
  initial begin
    conversion_start = 1'b0;
    serial_input_line = 1'b1;
    sck = 1'b0;
  end
  task automatic pins(input logic c, input logic s);
    @(posedge clk);
    conversion_start <= c;
    serial_input_line <= s;
  endtask : pins
  // Covers sync delay plus the output register
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic sck_fall(output logic b);
    @(posedge clk);
    sck <= 1'b1;
    repeat (3) @(posedge clk);
    sck <= 1'b0;
    settle();
    b = sdo_wire;
  endtask : sck_fall
  task automatic read_word(input bit at_select, input int falls, output logic [31:0] v);
    logic b;
    v = 32'h0;
    if (at_select) begin
      settle();
      v = {31'h0, sdo_wire};
    end
    for (int i = 0; i < falls; i++) begin
      sck_fall(b);
      v = {v[30:0], b};
    end
  endtask : read_word
endmodule : acr_host

// *** testbench/adc_chip_select_readout_modes_bench.sv ***
`timescale 1ns/1ns
module adc_chip_select_readout_modes_bench;
  import acr_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic conversion_start, serial_input_line, sck, serial_output_line_o, serial_output_line_oe;
  logic [RESULT_BITS-1:0] sample_in = 20'h0;
  logic overvoltage_clamp_flag = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] v, w;
  logic b;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  acr_readout DUT (.clk, .srst, .conversion_start, .serial_input_line, .sck, .serial_output_line_o,
    .serial_output_line_oe, .sample_in, .overvoltage_clamp_flag, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  acr_host host (.clk, .sdo_o(serial_output_line_o), .sdo_oe(serial_output_line_oe), .conversion_start,
    .serial_input_line, .sck);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic see_oe(input logic e);
    #1;
    check("output enable", {31'h0, e}, {31'h0, serial_output_line_oe});
  endtask : see_oe

  // Ready is registered, so the level at the falling edge is what the next rising edge takes
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check("write response", {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    logic ar_ok, r_ok;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge clk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic test_regs();
    axi_read(REG_CFG, v);
    check("cfg reset", {28'h0, CFG_RST}, v);
    axi_write(REG_CFG, 32'hf);
    axi_read(REG_CFG, v);
    check("cfg readback", 32'hf, v);
    axi_read(8'h0c, v);
    check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_write(REG_CFG, 32'h0);
  endtask : test_regs

  task automatic test_3w();
    sample_in <= 20'ha5c3e;
    host.pins(1'b1, 1'b1);
    host.settle();
    see_oe(1'b0);
    // Brief select of another device mid-conversion
    host.pins(1'b0, 1'b1);
    host.pins(1'b1, 1'b1);
    repeat (40) @(posedge clk);
    sample_in <= 20'h1b7d2;
    host.pins(1'b0, 1'b1);
    host.read_word(1'b1, 19, v);
    check("3-wire word", 32'ha5c3e, v);
    host.sck_fall(b);
    see_oe(1'b0);
    host.pins(1'b1, 1'b1);
    repeat (40) @(posedge clk);
    host.pins(1'b0, 1'b1);
    host.read_word(1'b1, 4, v);
    check("3-wire head", 32'h3, v);
    host.pins(1'b1, 1'b1);
    host.settle();
    see_oe(1'b0);
    repeat (40) @(posedge clk);
  endtask : test_3w

  task automatic test_busy();
    axi_write(REG_CFG, 32'he);
    overvoltage_clamp_flag <= 1'b1;
    sample_in <= 20'h8e071;
    host.pins(1'b0, 1'b1);
    host.pins(1'b1, 1'b1);
    host.settle();
    see_oe(1'b0);
    host.pins(1'b0, 1'b1);
    repeat (12) @(posedge clk);
    see_oe(1'b0);
    repeat (20) @(posedge clk);
    see_oe(1'b1);
    check("ready level", 32'h0, {31'h0, serial_output_line_o});
    host.read_word(1'b0, 20, v);
    check("busy word", 32'h8e071, v);
    host.read_word(1'b0, 6, v);
    check("status bits", 32'h38, v);
    host.sck_fall(b);
    see_oe(1'b0);
  endtask : test_busy

  task automatic test_4w();
    axi_write(REG_CFG, 32'h0);
    sample_in <= 20'h5f30c;
    host.pins(1'b1, 1'b1);
    // Serial input lent to another device early in the conversion
    host.pins(1'b1, 1'b0);
    host.pins(1'b1, 1'b1);
    repeat (40) @(posedge clk);
    see_oe(1'b0);
    host.pins(1'b1, 1'b0);
    host.read_word(1'b1, 9, v);
    check("4-wire head", 32'h17c, v);
    host.pins(1'b1, 1'b1);
    host.settle();
    see_oe(1'b0);
  endtask : test_4w

  task automatic test_turbo();
    axi_write(REG_CFG, 32'h3);
    host.pins(1'b0, 1'b1);
    sample_in <= 20'h2468a;
    host.pins(1'b1, 1'b1);
    repeat (8) @(posedge clk);
    host.pins(1'b1, 1'b0);
    host.read_word(1'b1, 0, v);
    repeat (30) @(posedge clk);
    host.read_word(1'b0, 19, w);
    check("turbo word", 32'h5f30c, {12'h0, v[0], w[18:0]});
    host.read_word(1'b0, 6, v);
    check("turbo status bits", 32'h24, v);
    host.sck_fall(b);
    see_oe(1'b0);
    host.pins(1'b1, 1'b1);
    axi_read(REG_RESULT, v);
    check("result reg", 32'h2468a, v);
  endtask : test_turbo

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    test_regs();
    test_3w();
    test_busy();
    test_4w();
    test_turbo();
    give_verdict();
  end

  // Whole run needs about 1000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      give_verdict();
    end
  end
endmodule : adc_chip_select_readout_modes_bench
